// ### rtl/ref_input_select_regs.sv
// Reference input select and status slew registers behind an AXI4-Lite slave.
//
// Overview of operation
// - Second status slew field bits 3:2, reset 0.
// - First status slew field bits 1:0, reset 0.
// - Secondary buffer mode bits 7:6, reset 2.
// - Primary buffer mode bits 5:4, reset 1.
// - Synth b select bits 3:2, reset 1.
// - Synth b pin mode: low/mid secondary, high auto.
// - Synth a select bits 1:0, reset 1.
// - Synth a pin mode: low primary, else auto.
// - Automatic mode prefers primary, else secondary.
`timescale 1ns/1ns
module ref_input_select_regs
  import ref_sel_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // AXI4-Lite write address.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Three-level select pin, seen as two comparator levels.
  input  wire logic        ref_pin_above_low,
  input  wire logic        ref_pin_above_mid,
  // Reference availability.
  input  wire logic        primary_ok,
  input  wire logic        secondary_ok,
  // Configuration outputs.
  output logic [1:0]       second_status_edge_rate,
  output logic [1:0]       first_status_edge_rate,
  output logic [1:0]       secondary_buffer_mode,
  output logic [1:0]       primary_buffer_mode,
  // Reference choice per synthesizer, high for secondary.
  output logic             synth_a_use_secondary,
  output logic             synth_b_use_secondary
);

  logic       rst_meta_r;
  logic       rst_sync_r;
  logic       rstn_int;
  logic [1:0] above_low_sync_r;
  logic [1:0] above_mid_sync_r;
  logic [1:0] pri_ok_sync_r;
  logic [1:0] sec_ok_sync_r;
  pin_level_t pin_level;
  logic [1:0] sec_slew_r;
  logic [1:0] first_slew_r;
  logic [1:0] sec_buf_r;
  logic [1:0] pri_buf_r;
  ref_sel_t   synth_b_ref_select;
  ref_sel_t   synth_a_ref_select;
  logic [11:0] awaddr_r;
  logic        aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        w_held_r;
  logic        do_write;
  logic        a_sec_nxt;
  logic        b_sec_nxt;
  logic [31:0] rdata_nxt;
  logic        rd_hit;
  logic        slew_wr;
  logic        insel_wr;

  // Reset release through two flip-flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rstn_int = rst_sync_r;

  // Pin inputs pass two flip-flops.
  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      above_low_sync_r <= 2'h0;
      above_mid_sync_r <= 2'h0;
      pri_ok_sync_r    <= 2'h0;
      sec_ok_sync_r    <= 2'h0;
    end else begin
      above_low_sync_r <= {above_low_sync_r[0], ref_pin_above_low};
      above_mid_sync_r <= {above_mid_sync_r[0], ref_pin_above_mid};
      pri_ok_sync_r    <= {pri_ok_sync_r[0], primary_ok};
      sec_ok_sync_r    <= {sec_ok_sync_r[0], secondary_ok};
    end
  end

  always_comb begin
    if (above_mid_sync_r[1]) begin
      pin_level = PIN_HIGH;
    end else if (above_low_sync_r[1]) begin
      pin_level = PIN_MID;
    end else begin
      pin_level = PIN_LOW;
    end
  end

  // Write channel capture; address and data taken in either order.
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      awaddr_r      <= 12'h000;
      aw_held_r     <= 1'b0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r  <= s_axi_awaddr;
        aw_held_r <= 1'b1;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      w_held_r     <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        w_held_r <= 1'b1;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r == SLEW_ADDR || awaddr_r == INSEL_ADDR) ?
                      RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register write strobes; only the low byte holds fields.
  assign slew_wr  = do_write && awaddr_r == SLEW_ADDR && wstrb_r[0];
  assign insel_wr = do_write && awaddr_r == INSEL_ADDR && wstrb_r[0];

  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      sec_slew_r <= SLEW_RST;
    end else if (slew_wr) begin
      sec_slew_r <= wdata_r[SEC_SLEW_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      first_slew_r <= SLEW_RST;
    end else if (slew_wr) begin
      first_slew_r <= wdata_r[FIRST_SLEW_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      sec_buf_r <= SEC_BUF_RST;
    end else if (insel_wr) begin
      sec_buf_r <= wdata_r[SEC_BUF_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      pri_buf_r <= PRI_BUF_RST;
    end else if (insel_wr) begin
      pri_buf_r <= wdata_r[PRI_BUF_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      synth_b_ref_select <= ref_sel_t'(SEL_RST);
    end else if (insel_wr) begin
      synth_b_ref_select <= ref_sel_t'(wdata_r[SYNTH_B_LSB +: 2]);
    end
  end

  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      synth_a_ref_select <= ref_sel_t'(SEL_RST);
    end else if (insel_wr) begin
      synth_a_ref_select <= ref_sel_t'(wdata_r[SYNTH_A_LSB +: 2]);
    end
  end

  // Reference choice per synthesizer.
  always_comb begin
    a_sec_nxt = !pri_ok_sync_r[1] && sec_ok_sync_r[1];
    b_sec_nxt = a_sec_nxt;
    unique case (synth_a_ref_select)
      SEL_AUTO: a_sec_nxt = !pri_ok_sync_r[1] && sec_ok_sync_r[1];
      SEL_PIN:  a_sec_nxt = (pin_level == PIN_LOW) ? 1'b0 :
                            (!pri_ok_sync_r[1] && sec_ok_sync_r[1]);
      SEL_PRI:  a_sec_nxt = 1'b0;
      SEL_SEC:  a_sec_nxt = 1'b1;
    endcase
    unique case (synth_b_ref_select)
      SEL_AUTO: b_sec_nxt = !pri_ok_sync_r[1] && sec_ok_sync_r[1];
      SEL_PIN:  b_sec_nxt = (pin_level != PIN_HIGH) ? 1'b1 :
                            (!pri_ok_sync_r[1] && sec_ok_sync_r[1]);
      SEL_PRI:  b_sec_nxt = 1'b0;
      SEL_SEC:  b_sec_nxt = 1'b1;
    endcase
  end

  // Outputs from flip-flops.
  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      second_status_edge_rate <= SLEW_RST;
      first_status_edge_rate  <= SLEW_RST;
      secondary_buffer_mode   <= SEC_BUF_RST;
      primary_buffer_mode     <= PRI_BUF_RST;
      synth_a_use_secondary   <= 1'b0;
      synth_b_use_secondary   <= 1'b0;
    end else begin
      second_status_edge_rate <= sec_slew_r;
      first_status_edge_rate  <= first_slew_r;
      secondary_buffer_mode   <= sec_buf_r;
      primary_buffer_mode     <= pri_buf_r;
      synth_a_use_secondary   <= a_sec_nxt;
      synth_b_use_secondary   <= b_sec_nxt;
    end
  end

  // Read data mux.
  always_comb begin
    rd_hit    = 1'b1;
    rdata_nxt = 32'h0000_0000;
    unique case (s_axi_araddr)
      SLEW_ADDR:  rdata_nxt = {28'h0000000, sec_slew_r, first_slew_r};
      INSEL_ADDR: rdata_nxt = {24'h000000, sec_buf_r, pri_buf_r,
                               synth_b_ref_select, synth_a_ref_select};
      STATE_ADDR: rdata_nxt = {26'h0000000, pin_level, pri_ok_sync_r[1],
                               sec_ok_sync_r[1], b_sec_nxt, a_sec_nxt};
      default:    rd_hit = 1'b0;
    endcase
  end

  // Read channel: address taken, data one cycle later.
  always_ff @(posedge clk or negedge rstn_int) begin
    if (!rstn_int) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_nxt;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ### rtl/ref_sel_pkg.sv
// Package of register offsets, field layouts and codes for the reference select registers.
package ref_sel_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0]  SLEW_IDX       = 8'h31;
  localparam logic [7:0]  INSEL_IDX      = 8'h32;
  localparam logic [11:0] SLEW_ADDR      = 12'h0c4;
  localparam logic [11:0] INSEL_ADDR     = 12'h0c8;
  localparam logic [11:0] STATE_ADDR     = 12'h0cc;

  // Field positions.
  localparam int SEC_SLEW_LSB  = 2;
  localparam int FIRST_SLEW_LSB = 0;
  localparam int SEC_BUF_LSB   = 6;
  localparam int PRI_BUF_LSB   = 4;
  localparam int SYNTH_B_LSB   = 2;
  localparam int SYNTH_A_LSB   = 0;

  // Reset values.
  localparam logic [1:0] SLEW_RST    = 2'h0;
  localparam logic [1:0] SEC_BUF_RST = 2'h2;
  localparam logic [1:0] PRI_BUF_RST = 2'h1;
  localparam logic [1:0] SEL_RST     = 2'h1;

  // Edge rate codes.
  localparam logic [1:0] SLEW_FAST = 2'h0;
  localparam logic [1:0] SLEW_SLOW = 2'h2;

  // Input buffer modes.
  localparam logic [1:0] BUF_SINGLE  = 2'h0;
  localparam logic [1:0] BUF_DIFF    = 2'h1;
  localparam logic [1:0] BUF_CRYSTAL = 2'h2;
  localparam logic [1:0] BUF_OFF     = 2'h3;

  // Reference select codes.
  typedef enum logic [1:0] {
    SEL_AUTO = 2'b00,
    SEL_PIN  = 2'b01,
    SEL_PRI  = 2'b10,
    SEL_SEC  = 2'b11
  } ref_sel_t;

  // Decoded select pin level.
  typedef enum logic [1:0] {
    PIN_LOW  = 2'b00,
    PIN_MID  = 2'b01,
    PIN_HIGH = 2'b10
  } pin_level_t;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### dv/ref_input_select_regs_monitor.sv
// Checker of bus and configuration ports of the reference select registers.
`timescale 1ns/1ns
module ref_input_select_regs_monitor
  import ref_sel_pkg::*;
(
  input wire logic        clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, synth_a_use_secondary, synth_b_use_secondary,
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp, first_status_edge_rate,
  input wire logic [1:0]  second_status_edge_rate, secondary_buffer_mode, primary_buffer_mode,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic mapped;
  assign mapped = s_axi_araddr inside {SLEW_ADDR, INSEL_ADDR, STATE_ADDR};
  a_reset_values: assert property ($rose(rstn) |->
    {second_status_edge_rate, first_status_edge_rate} == 4'h0 && secondary_buffer_mode == 2'h2
    && primary_buffer_mode == 2'h1 && !synth_a_use_secondary && !synth_b_use_secondary)
    else $error("outputs differ from reset values");
  a_config_cause: assert property (
    $changed({second_status_edge_rate, first_status_edge_rate, secondary_buffer_mode,
    primary_buffer_mode}) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("configuration changed without a write");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && !mapped |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_mapped_read: assert property (s_axi_arvalid && s_axi_arready && mapped |=>
    s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0) else $error("mapped read bad");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready not a pulse");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
endmodule
bind ref_input_select_regs ref_input_select_regs_monitor ref_input_select_regs_monitor_i (.*);

// ### dv/ref_input_select_regs_tb.sv
// Random and corner tests of the reference select registers.
`timescale 1ns/1ns
module ref_input_select_regs_tb;
  import ref_sel_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        ref_pin_above_low = 1'b0, ref_pin_above_mid = 1'b0;
  logic        primary_ok = 1'b1, secondary_ok = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        synth_a_use_secondary, synth_b_use_secondary;
  logic [1:0]  s_axi_bresp, s_axi_rresp, second_status_edge_rate, first_status_edge_rate;
  logic [1:0]  secondary_buffer_mode, primary_buffer_mode;
  int          err_total = 0, num_checks = 0;
  integer      seed = 25;

  ref_input_select_regs ref_input_select_regs_i (.*);

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask

  function automatic logic exp_sec(input logic [1:0] sel, input int pin, input logic b,
                                   input logic po, input logic so);
    logic au;
    au = !po && so;
    case (sel)
      2'h0: return au;
      2'h1: return b ? (pin == 2 ? au : 1'b1) : (pin == 0 ? 1'b0 : au);
      2'h2: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict;
  end

  initial begin
    logic [31:0] v, p;
    logic [7:0]  sel;
    logic        ea, eb;
    int          pin;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(SLEW_ADDR, 32'h0, RESP_OKAY);
    rd(INSEL_ADDR, 32'h95, RESP_OKAY);
    chk("modes", {SEC_BUF_RST, PRI_BUF_RST}, {secondary_buffer_mode, primary_buffer_mode});
    chk("rates", {SLEW_RST, SLEW_RST}, {second_status_edge_rate, first_status_edge_rate});
    chk("synth a", exp_sec(SEL_RST, 0, 1'b0, 1'b1, 1'b1), synth_a_use_secondary);
    chk("synth b", exp_sec(SEL_RST, 0, 1'b1, 1'b1, 1'b1), synth_b_use_secondary);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      p = $random(seed);
      pin = (p[1:0] == 2'h3) ? 1 : int'(p[1:0]);
      sel = {v[7:4], i[3:0]};
      ref_pin_above_low <= pin != 0;
      ref_pin_above_mid <= pin == 2;
      primary_ok <= p[2];
      secondary_ok <= p[3];
      wr(INSEL_ADDR, {24'h0, sel}, 4'h1, RESP_OKAY);
      wr(SLEW_ADDR, {24'h0, v[15:8]}, 4'h1, RESP_OKAY);
      repeat (5) @(posedge clk);
      rd(INSEL_ADDR, {24'h0, sel}, RESP_OKAY);
      rd(SLEW_ADDR, {28'h0, v[11:8]}, RESP_OKAY);
      chk("rates", v[11:8], {second_status_edge_rate, first_status_edge_rate});
      chk("modes", sel[7:4], {secondary_buffer_mode, primary_buffer_mode});
      ea = exp_sec(sel[1:0], pin, 1'b0, p[2], p[3]);
      eb = exp_sec(sel[3:2], pin, 1'b1, p[2], p[3]);
      chk("synth a", ea, synth_a_use_secondary);
      chk("synth b", eb, synth_b_use_secondary);
    end
    $display("test select codes done");
    rd(STATE_ADDR, {26'h0, pin[1:0], p[2], p[3], eb, ea}, RESP_OKAY);
    wr(12'h0d0, 32'hff, 4'hf, RESP_SLVERR);
    rd(12'h0d0, 32'h0, RESP_SLVERR);
    wr(STATE_ADDR, 32'hff, 4'hf, RESP_SLVERR);
    wr(INSEL_ADDR, 32'h0, 4'h0, RESP_OKAY);
    rd(INSEL_ADDR, {24'h0, sel}, RESP_OKAY);
    $display("test refusals done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(INSEL_ADDR, {24'h0, SEC_BUF_RST, PRI_BUF_RST, SEL_RST, SEL_RST}, RESP_OKAY);
    rd(SLEW_ADDR, 32'h0, RESP_OKAY);
    chk("modes", {SEC_BUF_RST, PRI_BUF_RST}, {secondary_buffer_mode, primary_buffer_mode});
    chk("rates", {SLEW_RST, SLEW_RST}, {second_status_edge_rate, first_status_edge_rate});
    $display("test mid-run reset done");
    print_verdict;
  end
endmodule
